// >>> core/msp_pkg.sv
// Package of offsets, field positions and reset values for the media PCS register set
package msp_pkg;
    // ------------------------------------------------------------
    // Register indexes and address width
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_TX_CRC      = 8'h16;
    localparam logic [7:0] IDX_PCS_CTRL    = 8'h17;
    localparam logic [7:0] IDX_PCS_STATUS  = 8'h18;
    localparam logic [7:0] IDX_ADV_ABILITY = 8'h19;
    localparam int         ADDR_W          = 10;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SEL_HI      = 15;
    localparam int SEL_LO      = 14;
    localparam int PDET_BIT    = 13;
    localparam int FORCE_BIT   = 11;
    localparam int POL_IN_BIT  = 6;
    localparam int POL_OUT_BIT = 5;
    localparam int ODD_BIT     = 4;
    localparam int HLS_BIT     = 2;
    localparam int FEFI_BIT    = 1;
    localparam int FEFI_VAL    = 0;
    localparam logic [1:0] SEL_MEDIA = 2'h0;
    localparam logic [1:0] SEL_MAC   = 2'h1;
    // ------------------------------------------------------------
    // Reset values and counter limit
    // ------------------------------------------------------------
    localparam logic [15:0] CTRL_RESET = 16'h0010;
    localparam logic [15:0] ADV_RESET  = 16'h0000;
    localparam logic [7:0]  CNT_MAX    = 8'hff;
endpackage : msp_pkg

// >>> core/msp_regs.sv
// Media SerDes PCS management register set on an Avalon-MM slave
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module msp_regs (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             avs_response_err,
    input  wire logic        media_tx_crc_err,
    input  wire logic        mac_tx_crc_err,
    input  wire logic        media_link_up,
    input  wire logic        cl37_an_enable,
    input  wire logic [15:0] internal_adv_word,
    input  wire logic [1:0]  remote_fault_sent,
    input  wire logic        sync_lost,
    input  wire logic        bad_code_group,
    input  wire logic        link_100_up,
    input  wire logic        link_10_up,
    input  wire logic        lp_an_restart,
    input  wire logic [1:0]  lp_remote_fault,
    input  wire logic [3:0]  lp_abilities,
    input  wire logic        lp_an_capable,
    input  wire logic        an_complete,
    input  wire logic        signal_detect,
    input  wire logic        serdes_rx_in,
    output logic             serdes_rx_data,
    input  wire logic        serdes_tx_data,
    output logic             serdes_tx_out,
    output logic [15:0]      adv_word_out,
    output logic             parallel_detect_en,
    output logic             inhibit_odd_start_delay,
    output logic             force_halt_line_state,
    output logic             override_far_end_fault,
    output logic             far_end_fault_override_value
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [1:0]  sel_q,   sel_d;
    logic [7:0]  media_cnt_q, media_cnt_d;
    logic [7:0]  mac_cnt_q,   mac_cnt_d;
    logic [15:0] ctrl_q,  ctrl_d;
    logic [15:0] adv_q,   adv_d;
    logic        sync_lost_q, sync_lost_d;
    logic        bad_cg_q,    bad_cg_d;
    logic [31:0] rdata_q, rdata_d;
    logic        ack_q,   ack_d;
    logic        err_q,   err_d;
    logic        sync_s1_q, sync_s2_q, sync_s3_q;
    logic        badcg_s1_q, badcg_s2_q, badcg_s3_q;
    logic [7:0]  index;
    logic        aligned;
    logic        hit;
    logic        req;
    logic        wr_ok;
    logic        rd_status;
    logic [15:0] status_word;
    logic [15:0] wmask;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign req       = (avs_read | avs_write) & ~ack_q;
    assign index     = avs_address[9:2];
    assign aligned   = (avs_address[1:0] == 2'h0);
    assign hit       = aligned & ((index == msp_pkg::IDX_TX_CRC) |
                                  (index == msp_pkg::IDX_PCS_CTRL) |
                                  (index == msp_pkg::IDX_PCS_STATUS) |
                                  (index == msp_pkg::IDX_ADV_ABILITY));
    assign wr_ok     = ack_q & avs_write & hit;
    assign rd_status = req & avs_read & aligned & (index == msp_pkg::IDX_PCS_STATUS);
    assign wmask     = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign avs_waitrequest  = ~ack_q;
    assign avs_readdata     = rdata_q;
    assign avs_response_err = err_q;

    // ------------------------------------------------------------
    // Sync of link-side event levels (three stages)
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_s1_q  <= 1'b0;
            sync_s2_q  <= 1'b0;
            sync_s3_q  <= 1'b0;
            badcg_s1_q <= 1'b0;
            badcg_s2_q <= 1'b0;
            badcg_s3_q <= 1'b0;
        end else begin
            sync_s1_q  <= sync_lost;
            sync_s2_q  <= sync_s1_q;
            sync_s3_q  <= sync_s2_q;
            badcg_s1_q <= bad_code_group;
            badcg_s2_q <= badcg_s1_q;
            badcg_s3_q <= badcg_s2_q;
        end
    end

    // ------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------
    always_comb begin
        status_word      = 16'h0000;
        status_word[15]  = sync_lost_q;
        status_word[14]  = bad_cg_q;
        status_word[13]  = link_100_up;
        status_word[12]  = link_10_up;
        status_word[11]  = lp_an_restart;
        status_word[9:8] = lp_remote_fault;
        status_word[7:4] = lp_abilities;
        status_word[3]   = lp_an_capable;
        status_word[2]   = media_link_up;
        status_word[1]   = an_complete;
        status_word[0]   = signal_detect;
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        sel_d       = sel_q;
        media_cnt_d = media_cnt_q;
        mac_cnt_d   = mac_cnt_q;
        ctrl_d      = ctrl_q;
        adv_d       = adv_q;
        sync_lost_d = sync_lost_q;
        bad_cg_d    = bad_cg_q;
        rdata_d     = 32'h0000_0000;
        ack_d       = req;
        err_d       = req & ~hit;
        // Counters run only with media link up; hold at full scale
        if (media_link_up && media_tx_crc_err && media_cnt_q != msp_pkg::CNT_MAX) begin
            media_cnt_d = media_cnt_q + 8'h01;
        end
        if (media_link_up && mac_tx_crc_err && mac_cnt_q != msp_pkg::CNT_MAX) begin
            mac_cnt_d = mac_cnt_q + 8'h01;
        end
        // Event flags: read clears, a new event in the same cycle wins
        if (rd_status) begin
            sync_lost_d = 1'b0;
            bad_cg_d    = 1'b0;
        end
        if (sync_s2_q && sync_s3_q) begin
            sync_lost_d = 1'b1;
        end
        if (badcg_s2_q && badcg_s3_q) begin
            bad_cg_d = 1'b1;
        end
        if (wr_ok) begin
            case (index)
                msp_pkg::IDX_TX_CRC: begin
                    if (avs_byteenable[1]) begin
                        sel_d = avs_writedata[msp_pkg::SEL_HI:msp_pkg::SEL_LO];
                    end
                end
                msp_pkg::IDX_PCS_CTRL: begin
                    ctrl_d = (ctrl_q & ~wmask) | (avs_writedata[15:0] & wmask);
                end
                msp_pkg::IDX_ADV_ABILITY: begin
                    if (ctrl_q[msp_pkg::FORCE_BIT]) begin
                        adv_d = (adv_q & ~wmask) | (avs_writedata[15:0] & wmask);
                    end
                end
                default: begin
                end
            endcase
        end
        if (req && avs_read && hit) begin
            case (index)
                msp_pkg::IDX_TX_CRC: begin
                    rdata_d[15:14] = sel_q;
                    case (sel_q)
                        msp_pkg::SEL_MEDIA: rdata_d[7:0] = media_cnt_q;
                        msp_pkg::SEL_MAC:   rdata_d[7:0] = mac_cnt_q;
                        default:            rdata_d[7:0] = 8'h00;
                    endcase
                end
                msp_pkg::IDX_PCS_CTRL: begin
                    rdata_d[15:0]  = ctrl_q;
                    rdata_d[15:14] = remote_fault_sent;
                end
                msp_pkg::IDX_PCS_STATUS: begin
                    rdata_d[15:0] = status_word;
                end
                default: begin
                    rdata_d[15:0] = adv_q;
                end
            endcase
        end
        // Reserved control bits stay zero
        ctrl_d[15:14] = 2'h0;
        ctrl_d[12]    = 1'b0;
        ctrl_d[10:7]  = 4'h0;
        ctrl_d[3]     = 1'b0;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sel_q       <= msp_pkg::SEL_MEDIA;
            media_cnt_q <= 8'h00;
            mac_cnt_q   <= 8'h00;
            ctrl_q      <= msp_pkg::CTRL_RESET;
            adv_q       <= msp_pkg::ADV_RESET;
            sync_lost_q <= 1'b0;
            bad_cg_q    <= 1'b0;
            rdata_q     <= 32'h0000_0000;
            ack_q       <= 1'b0;
            err_q       <= 1'b0;
        end else begin
            sel_q       <= sel_d;
            media_cnt_q <= media_cnt_d;
            mac_cnt_q   <= mac_cnt_d;
            ctrl_q      <= ctrl_d;
            adv_q       <= adv_d;
            sync_lost_q <= sync_lost_d;
            bad_cg_q    <= bad_cg_d;
            rdata_q     <= rdata_d;
            ack_q       <= ack_d;
            err_q       <= err_d;
        end
    end

    // ------------------------------------------------------------
    // Datapath controls
    // ------------------------------------------------------------
    assign serdes_rx_data = serdes_rx_in ^ ctrl_q[msp_pkg::POL_IN_BIT];
    assign serdes_tx_out  = serdes_tx_data ^ ctrl_q[msp_pkg::POL_OUT_BIT];
    assign adv_word_out   = ctrl_q[msp_pkg::FORCE_BIT] ? adv_q : internal_adv_word;
    assign parallel_detect_en = ctrl_q[msp_pkg::PDET_BIT] & cl37_an_enable;
    assign inhibit_odd_start_delay      = ctrl_q[msp_pkg::ODD_BIT];
    assign force_halt_line_state        = ctrl_q[msp_pkg::HLS_BIT];
    assign override_far_end_fault       = ctrl_q[msp_pkg::FEFI_BIT];
    assign far_end_fault_override_value = ctrl_q[msp_pkg::FEFI_VAL];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_cnt_saturate: assert property (@(posedge clk) disable iff (rst)
        media_cnt_q == msp_pkg::CNT_MAX |=> media_cnt_q == msp_pkg::CNT_MAX)
        else $error("media counter left saturation");
    a_cnt_link_gate: assert property (@(posedge clk) disable iff (rst)
        !media_link_up |=> $stable(media_cnt_q) && $stable(mac_cnt_q))
        else $error("counter moved while link down");
    a_cnt_step: assert property (@(posedge clk) disable iff (rst)
        media_link_up && media_tx_crc_err && media_cnt_q < msp_pkg::CNT_MAX
        |=> media_cnt_q == $past(media_cnt_q) + 8'h01)
        else $error("counter failed to advance");
    a_adv_locked: assert property (@(posedge clk) disable iff (rst)
        !ctrl_q[msp_pkg::FORCE_BIT] |=> $stable(adv_q))
        else $error("advertised word written without force");
    a_adv_select: assert property (@(posedge clk) disable iff (rst)
        ctrl_q[msp_pkg::FORCE_BIT] |-> adv_word_out == adv_q)
        else $error("forced word not advertised");
    a_pdet_gate: assert property (@(posedge clk) disable iff (rst)
        !cl37_an_enable |-> !parallel_detect_en)
        else $error("parallel detect active without negotiation");
    a_sync_sticky: assert property (@(posedge clk) disable iff (rst)
        sync_s2_q && sync_s3_q |=> sync_lost_q)
        else $error("sync loss not captured");
    a_flag_hold: assert property (@(posedge clk) disable iff (rst)
        sync_lost_q && !rd_status |=> sync_lost_q)
        else $error("sync flag cleared without read");
    a_flag_clear: assert property (@(posedge clk) disable iff (rst)
        rd_status && !(sync_s2_q && sync_s3_q) |=> !sync_lost_q)
        else $error("sync flag survived read");
    a_bus_ack: assert property (@(posedge clk) disable iff (rst)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered in one cycle");

    // ------------------------------------------------------------
    // Checks on counters and control
    // ------------------------------------------------------------
    a_mac_step: assert property (@(posedge clk) disable iff (rst)
        media_link_up && mac_tx_crc_err && mac_cnt_q < msp_pkg::CNT_MAX
        |=> mac_cnt_q == $past(mac_cnt_q) + 8'h01)
        else $error("MAC counter failed to advance");
    a_media_hold: assert property (@(posedge clk) disable iff (rst)
        !media_tx_crc_err |=> $stable(media_cnt_q))
        else $error("media counter moved without error pulse");
    a_mac_hold: assert property (@(posedge clk) disable iff (rst)
        !mac_tx_crc_err |=> $stable(mac_cnt_q))
        else $error("MAC counter moved without error pulse");
    a_sel_write: assert property (@(posedge clk) disable iff (rst)
        wr_ok && index == msp_pkg::IDX_TX_CRC && avs_byteenable[1]
        |=> sel_q == $past(avs_writedata[msp_pkg::SEL_HI:msp_pkg::SEL_LO]))
        else $error("counter select not written");
    a_read_media: assert property (@(posedge clk) disable iff (rst)
        req && avs_read && aligned && index == msp_pkg::IDX_TX_CRC && sel_q == msp_pkg::SEL_MEDIA
        |=> avs_readdata[7:0] == $past(media_cnt_q))
        else $error("media count not selected");
    a_read_mac: assert property (@(posedge clk) disable iff (rst)
        req && avs_read && aligned && index == msp_pkg::IDX_TX_CRC && sel_q == msp_pkg::SEL_MAC
        |=> avs_readdata[7:0] == $past(mac_cnt_q))
        else $error("MAC count not selected");
    a_read_rsvd: assert property (@(posedge clk) disable iff (rst)
        req && avs_read && aligned && index == msp_pkg::IDX_TX_CRC && sel_q[1]
        |=> avs_readdata[7:0] == 8'h00)
        else $error("reserved select returned a count");
    a_rf_sent: assert property (@(posedge clk) disable iff (rst)
        req && avs_read && aligned && index == msp_pkg::IDX_PCS_CTRL
        |=> avs_readdata[15:14] == $past(remote_fault_sent))
        else $error("sent remote fault not reported");
    a_pol_in: assert property (@(posedge clk) disable iff (rst)
        serdes_rx_data == (ctrl_q[msp_pkg::POL_IN_BIT] ? !serdes_rx_in : serdes_rx_in))
        else $error("receive polarity wrong");
    a_pol_out: assert property (@(posedge clk) disable iff (rst)
        serdes_tx_out == (ctrl_q[msp_pkg::POL_OUT_BIT] ? !serdes_tx_data : serdes_tx_data))
        else $error("transmit polarity wrong");
    a_halt_force: assert property (@(posedge clk) disable iff (rst)
        wr_ok && index == msp_pkg::IDX_PCS_CTRL && avs_byteenable[0]
        |=> force_halt_line_state == $past(avs_writedata[msp_pkg::HLS_BIT]))
        else $error("halt line state control not applied");
    a_fefi_force: assert property (@(posedge clk) disable iff (rst)
        wr_ok && index == msp_pkg::IDX_PCS_CTRL && avs_byteenable[0]
        |=> {override_far_end_fault, far_end_fault_override_value}
            == $past(avs_writedata[msp_pkg::FEFI_BIT:msp_pkg::FEFI_VAL]))
        else $error("far-end fault override not applied");
    a_odd_start: assert property (@(posedge clk) disable iff (rst)
        wr_ok && index == msp_pkg::IDX_PCS_CTRL && avs_byteenable[0]
        |=> inhibit_odd_start_delay == $past(avs_writedata[msp_pkg::ODD_BIT]))
        else $error("odd-start control not applied");
    a_pdet_follow: assert property (@(posedge clk) disable iff (rst)
        cl37_an_enable |-> parallel_detect_en == ctrl_q[msp_pkg::PDET_BIT])
        else $error("parallel detect ignores its control bit");

    // ------------------------------------------------------------
    // Checks on status readout
    // ------------------------------------------------------------
    a_stat_low: assert property (@(posedge clk) disable iff (rst)
        rd_status |=> avs_readdata[3:0]
            == $past({lp_an_capable, media_link_up, an_complete, signal_detect}))
        else $error("low status bits wrong");
    a_stat_lp: assert property (@(posedge clk) disable iff (rst)
        rd_status |=> avs_readdata[7:4] == $past(lp_abilities))
        else $error("partner ability bits wrong");
    a_stat_rf: assert property (@(posedge clk) disable iff (rst)
        rd_status |=> avs_readdata[9:8] == $past(lp_remote_fault))
        else $error("received remote fault wrong");
    a_stat_link: assert property (@(posedge clk) disable iff (rst)
        rd_status |=> avs_readdata[13:11] == $past({link_100_up, link_10_up, lp_an_restart}))
        else $error("link or restart bits wrong");
    a_stat_flags: assert property (@(posedge clk) disable iff (rst)
        rd_status |=> avs_readdata[15:14] == $past({sync_lost_q, bad_cg_q}))
        else $error("event flags not reported");
    a_badcg_sticky: assert property (@(posedge clk) disable iff (rst)
        badcg_s2_q && badcg_s3_q |=> bad_cg_q)
        else $error("bad code-group not captured");
    a_badcg_clear: assert property (@(posedge clk) disable iff (rst)
        rd_status && !(badcg_s2_q && badcg_s3_q) |=> !bad_cg_q)
        else $error("bad code-group flag survived read");

    // ------------------------------------------------------------
    // Checks on bus answers
    // ------------------------------------------------------------
    a_bus_err: assert property (@(posedge clk) disable iff (rst)
        req && !hit |=> avs_response_err && avs_readdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    a_bus_stand: assert property (@(posedge clk) disable iff (rst)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("answer stood longer than one cycle");
endmodule : msp_regs
`default_nettype wire

// >>> dv/msp_link_partner.sv
// Fiber link partner model: drives media status levels, events and CRC pulses
`timescale 1ns/1ps
`default_nettype none
module msp_link_partner (
    input  wire logic        clk,
    output logic             media_tx_crc_err,
    output logic             mac_tx_crc_err,
    output logic             sync_lost,
    output logic             bad_code_group,
    output logic             serdes_rx_in,
    output logic [15:0]      live
);
    // ------------------------------------------------------------
    // Line levels at time zero
    // ------------------------------------------------------------
    initial begin
        media_tx_crc_err = 1'b0;
        mac_tx_crc_err   = 1'b0;
        sync_lost        = 1'b0;
        bad_code_group   = 1'b0;
        serdes_rx_in     = 1'b0;
        live             = 16'h0000;
    end
    // ------------------------------------------------------------
    // Stimulus tasks, all changes just after a rising edge
    // ------------------------------------------------------------
    task automatic drive(input logic [15:0] v, input logic r);
        @(posedge clk);
        live         <= v;
        serdes_rx_in <= r;
    endtask : drive
    task automatic pulse(input logic mac, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            if (mac) mac_tx_crc_err <= 1'b1;
            else media_tx_crc_err <= 1'b1;
            @(posedge clk);
            media_tx_crc_err <= 1'b0;
            mac_tx_crc_err   <= 1'b0;
        end
    endtask : pulse
    task automatic glitch(input logic bad);
        @(posedge clk);
        if (bad) bad_code_group <= 1'b1;
        else sync_lost <= 1'b1;
        repeat (4) @(posedge clk);
        sync_lost      <= 1'b0;
        bad_code_group <= 1'b0;
    endtask : glitch
endmodule : msp_link_partner
`default_nettype wire

// >>> dv/test_media_serdes_pcs_regs.sv
// Self-checking testbench for the media PCS register set
`timescale 1ns/1ps
`default_nettype none
module test_media_serdes_pcs_regs;
    logic        clk, rst, avs_read, avs_write, avs_waitrequest, avs_response_err, er;
    logic [9:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic        media_tx_crc_err, mac_tx_crc_err, sync_lost, bad_code_group, serdes_rx_in;
    logic        serdes_rx_data, serdes_tx_data, serdes_tx_out, cl37_an_enable;
    logic        parallel_detect_en, inhibit_odd_start_delay, force_halt_line_state;
    logic        override_far_end_fault, far_end_fault_override_value;
    logic [15:0] live, internal_adv_word, adv_word_out, rd, ctl_vec;
    logic [1:0]  remote_fault_sent;
    int          num_errors, checks;
    assign ctl_vec = {9'h0, parallel_detect_en, inhibit_odd_start_delay, force_halt_line_state,
                      override_far_end_fault, far_end_fault_override_value, serdes_rx_data,
                      serdes_tx_out};
    msp_link_partner lp (.clk, .media_tx_crc_err, .mac_tx_crc_err, .sync_lost, .bad_code_group,
                         .serdes_rx_in, .live);
    msp_regs dut (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .avs_response_err,
        .media_tx_crc_err, .mac_tx_crc_err, .media_link_up(live[2]), .cl37_an_enable,
        .internal_adv_word, .remote_fault_sent, .sync_lost, .bad_code_group,
        .link_100_up(live[13]), .link_10_up(live[12]), .lp_an_restart(live[11]),
        .lp_remote_fault(live[9:8]), .lp_abilities(live[7:4]), .lp_an_capable(live[3]),
        .an_complete(live[1]), .signal_detect(live[0]), .serdes_rx_in, .serdes_rx_data,
        .serdes_tx_data, .serdes_tx_out, .adv_word_out, .parallel_detect_en,
        .inhibit_odd_start_delay, .force_halt_line_state, .override_far_end_fault,
        .far_end_fault_override_value);
    // ------------------------------------------------------------
    // Clock, watchdog and closing
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        chk("watchdog", 16'h0000, 16'h0001);
        give_verdict();
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] idx, input logic [15:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        avs_address   <= {idx, 2'h0};
        avs_read      <= !w;
        avs_write     <= w;
        avs_writedata <= {16'h0, wd};
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata[15:0];
        er = avs_response_err;
        if (n >= 50) chk("bus answer", 16'h0, 16'h1);
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic rchk(input logic [7:0] idx, input logic [15:0] e, input string nm);
        bus(1'b0, idx, 16'h0);
        chk(nm, e, rd);
    endtask : rchk
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        {cl37_an_enable, serdes_tx_data} = 2'h0;
        internal_adv_word = 16'h5a5a;
        remote_fault_sent = 2'h2;
        num_errors = 0;
        checks = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rchk(msp_pkg::IDX_PCS_CTRL, 16'h8010, "ctrl reset");
        rchk(msp_pkg::IDX_ADV_ABILITY, 16'h0000, "adv reset");
        rchk(msp_pkg::IDX_TX_CRC, 16'h0000, "counter reset");
        $display("test reset done");
        bus(1'b1, msp_pkg::IDX_ADV_ABILITY, 16'h1234);
        rchk(msp_pkg::IDX_ADV_ABILITY, 16'h0000, "adv locked");
        @(negedge clk);
        chk("adv out internal", 16'h5a5a, adv_word_out);
        bus(1'b1, msp_pkg::IDX_PCS_CTRL, 16'h0800);
        bus(1'b1, msp_pkg::IDX_ADV_ABILITY, 16'h1234);
        rchk(msp_pkg::IDX_ADV_ABILITY, 16'h1234, "adv written");
        @(negedge clk);
        chk("adv out forced", 16'h1234, adv_word_out);
        $display("test advertised done");
        lp.drive(16'h0000, 1'b1);
        @(posedge clk);
        cl37_an_enable <= 1'b1;
        serdes_tx_data <= 1'b1;
        bus(1'b1, msp_pkg::IDX_PCS_CTRL, 16'hffff);
        rchk(msp_pkg::IDX_PCS_CTRL, 16'ha877, "ctrl all ones");
        @(negedge clk);
        chk("controls set", 16'h007c, ctl_vec);
        @(posedge clk);
        cl37_an_enable <= 1'b0;
        @(negedge clk);
        chk("pdet without cl37", 16'h0000, {15'h0, parallel_detect_en});
        bus(1'b1, msp_pkg::IDX_PCS_CTRL, 16'h0002);
        rchk(msp_pkg::IDX_PCS_CTRL, 16'h8002, "ctrl override");
        @(negedge clk);
        chk("controls clear", 16'h000b, ctl_vec);
        $display("test control done");
        lp.drive(16'h2955, 1'b0);
        rchk(msp_pkg::IDX_PCS_STATUS, 16'h2955, "status a");
        lp.drive(16'h12aa, 1'b0);
        rchk(msp_pkg::IDX_PCS_STATUS, 16'h12aa, "status b");
        lp.glitch(1'b0);
        repeat (6) @(posedge clk);
        rchk(msp_pkg::IDX_PCS_STATUS, 16'h92aa, "sync lost set");
        rchk(msp_pkg::IDX_PCS_STATUS, 16'h12aa, "sync lost clear");
        lp.glitch(1'b1);
        repeat (6) @(posedge clk);
        rchk(msp_pkg::IDX_PCS_STATUS, 16'h52aa, "bad code set");
        rchk(msp_pkg::IDX_PCS_STATUS, 16'h12aa, "bad code clear");
        $display("test status done");
        lp.pulse(1'b0, 2);
        lp.drive(16'h2955, 1'b0);
        lp.pulse(1'b0, 3);
        lp.pulse(1'b1, 2);
        rchk(msp_pkg::IDX_TX_CRC, 16'h0003, "media count");
        bus(1'b1, msp_pkg::IDX_TX_CRC, 16'h40ff);
        rchk(msp_pkg::IDX_TX_CRC, 16'h4002, "mac count");
        bus(1'b1, msp_pkg::IDX_TX_CRC, 16'h8000);
        rchk(msp_pkg::IDX_TX_CRC, 16'h8000, "reserved select");
        bus(1'b1, msp_pkg::IDX_TX_CRC, 16'h0000);
        lp.pulse(1'b0, 260);
        rchk(msp_pkg::IDX_TX_CRC, 16'h00ff, "saturated count");
        $display("test counter done");
        bus(1'b0, 8'h1f, 16'h0);
        chk("unmapped err", 16'h0001, {15'h0, er});
        chk("unmapped data", 16'h0000, rd);
        $display("test unmapped done");
        give_verdict();
    end
endmodule : test_media_serdes_pcs_regs
`default_nettype wire
